// *** bbu_top.sv ***
// APB-reached bit-op and branch execution unit
`timescale 1ns/100ps
module bbu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  bbu_pkg::bbu_state_t      st_q;
  bbu_pkg::bbu_state_t      st_d;
  bbu_pkg::bbu_logic_res_t  lres;
  bbu_pkg::bbu_branch_res_t bres;
  logic                     setup;
  logic                     wr;
  logic                     go;
  logic                     mapped;
  logic [31:0]              rd_word;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  // execute uses the operands as they stand at the go write
  assign go    = wr && (paddr == bbu_pkg::OFF_CTRL) &&
                 pwdata[bbu_pkg::CTRL_GO_BIT];

  // zero wait state: read data was captured during setup
  assign pready  = psel && penable;
  assign prdata  = st_q.prdata;
  assign pslverr = st_q.pslverr;

  bbu_logic_unit u_logic (
    .instr (st_q.instr),
    .src   (st_q.src),
    .dst   (st_q.dst),
    .res   (lres)
  );

  bbu_branch_unit u_branch (
    .instr (st_q.instr),
    .flags (st_q.flags),
    .pc    (st_q.pc),
    .res   (bres)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    mapped  = 1'b1;
    rd_word = bbu_pkg::RST_RDATA;
    case (paddr)
      bbu_pkg::OFF_CTRL:   rd_word = bbu_pkg::RST_RDATA;
      bbu_pkg::OFF_INSTR:  rd_word = {16'h0000, st_q.instr};
      bbu_pkg::OFF_SRC:    rd_word = {16'h0000, st_q.src};
      bbu_pkg::OFF_DST:    rd_word = {16'h0000, st_q.dst};
      bbu_pkg::OFF_PC:     rd_word = {16'h0000, st_q.pc};
      bbu_pkg::OFF_FLAGS:  rd_word = {28'h000_0000, st_q.flags};
      bbu_pkg::OFF_RESULT: rd_word = {16'h0000, st_q.result};
      bbu_pkg::OFF_STATUS: rd_word = {29'h0000_0000, st_q.illegal,
                                      st_q.taken, st_q.done};
      default:             mapped  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (setup) begin
      st_d.prdata  = rd_word;
      st_d.pslverr = !mapped;
    end
    if (wr) begin
      case (paddr)
        bbu_pkg::OFF_INSTR: st_d.instr = pwdata[15:0];
        bbu_pkg::OFF_SRC:   st_d.src   = pwdata[15:0];
        bbu_pkg::OFF_DST:   st_d.dst   = pwdata[15:0];
        bbu_pkg::OFF_PC:    st_d.pc    = pwdata[15:0];
        bbu_pkg::OFF_FLAGS: st_d.flags = pwdata[3:0];
        bbu_pkg::OFF_STATUS: begin
          // write one to clear done; go only decodes at OFF_CTRL, so no go can share this write
          if (pwdata[bbu_pkg::ST_DONE_BIT]) begin
            st_d.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (go) begin
      st_d.done    = 1'b1;
      st_d.taken   = 1'b0;
      st_d.illegal = 1'b0;
      if (lres.valid) begin
        st_d.result  = lres.result;
        st_d.flags.n = lres.n;
        st_d.flags.z = lres.z;
        st_d.flags.v = 1'b0;
        if (lres.write_back) begin
          st_d.dst = lres.result;
        end
      end else if (bres.is_branch) begin
        // flags untouched on every branch path
        st_d.taken = bres.taken;
        if (bres.taken) begin
          st_d.pc = bres.target;
        end
      end else begin
        st_d.illegal = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [2:0] a_opc;
  logic       a_byte;
  logic [7:0] a_hi;
  assign a_opc  = st_q.instr[bbu_pkg::INSTR_OPC_HI:bbu_pkg::INSTR_OPC_LO];
  assign a_byte = st_q.instr[bbu_pkg::INSTR_BYTE_BIT];
  assign a_hi   = st_q.instr[15:8];

  sequence s_go_word(logic [2:0] o);
    go && !a_byte && (a_opc == o);
  endsequence

  sequence s_go_branch(logic [7:0] h);
    go && (a_hi == h);
  endsequence

  a_bit_set_word: assert property (
    s_go_word(3'h5) |=> st_q.dst == ($past(st_q.src) | $past(st_q.dst)))
    else $error("bit set word result wrong");

  a_bit_test_keep: assert property (
    s_go_word(3'h3) |=> $stable(st_q.dst) && $stable(st_q.src) &&
      st_q.flags.z == (($past(st_q.src) & $past(st_q.dst)) == 16'h0000))
    else $error("bit test changed an operand or wrong zero flag");

  a_bit_clear_word: assert property (
    s_go_word(3'h4) |=> st_q.dst == ($past(st_q.dst) & ~$past(st_q.src)))
    else $error("bit clear word result wrong");

  a_logic_flags_vc: assert property (
    go && lres.valid |=> !st_q.flags.v && st_q.flags.c == $past(st_q.flags.c)
      && st_q.flags.n == (a_byte ? st_q.result[7] : st_q.result[15]))
    else $error("logical op flag update wrong");

  a_byte_high_kept: assert property (
    go && lres.valid && a_byte |=> st_q.dst[15:8] == $past(st_q.dst[15:8]))
    else $error("byte form touched the high byte");

  a_branch_target: assert property (
    go && bres.taken |=> st_q.pc == $past(st_q.pc) +
      {{7{$past(st_q.instr[7])}}, $past(st_q.instr[7:0]), 1'b0})
    else $error("branch target wrong");

  a_branch_flags_kept: assert property (
    go && !lres.valid && bres.is_branch |=> $stable(st_q.flags))
    else $error("branch changed condition flags");

  a_branch_always: assert property (
    s_go_branch(8'h01) |=> st_q.taken)
    else $error("unconditional branch not taken");

  a_branch_zero: assert property (
    s_go_branch(8'h03) |=> st_q.taken == $past(st_q.flags.z))
    else $error("branch if zero decision wrong");

  a_branch_nonzero: assert property (
    s_go_branch(8'h02) |=> st_q.taken == !$past(st_q.flags.z))
    else $error("branch if nonzero decision wrong");

  a_branch_negative: assert property (
    s_go_branch(8'h81) |=> st_q.taken == $past(st_q.flags.n))
    else $error("branch if negative decision wrong");

  a_not_taken_pc: assert property (
    go && bres.is_branch && !lres.valid && !bres.taken |=> $stable(st_q.pc))
    else $error("untaken branch moved the pc");

endmodule

// *** bbu_pkg.sv ***
// package: constants, opcodes and carrier types of the bit-op/branch unit
package bbu_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INSTR  = 8'h04;
  localparam logic [7:0] OFF_SRC    = 8'h08;
  localparam logic [7:0] OFF_DST    = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_FLAGS  = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GO_BIT      = 0;
  localparam int unsigned ST_DONE_BIT      = 0;
  localparam int unsigned ST_TAKEN_BIT     = 1;
  localparam int unsigned ST_ILLEGAL_BIT   = 2;
  localparam int unsigned INSTR_BYTE_BIT   = 15;
  localparam int unsigned INSTR_OPC_HI     = 14;
  localparam int unsigned INSTR_OPC_LO     = 12;
  localparam int unsigned INSTR_SRC_HI     = 11;
  localparam int unsigned INSTR_SRC_LO     = 6;
  localparam int unsigned INSTR_DST_HI     = 5;
  localparam int unsigned INSTR_DST_LO     = 0;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [2:0] OPC_TEST  = 3'h3;
  localparam logic [2:0] OPC_CLEAR = 3'h4;
  localparam logic [2:0] OPC_SET   = 3'h5;
  // high byte of the branch opcodes, offset sits in the low byte
  localparam logic [7:0] BRH_ALWAYS   = 8'h01;
  localparam logic [7:0] BRH_NONZERO  = 8'h02;
  localparam logic [7:0] BRH_ZERO     = 8'h03;
  localparam logic [7:0] BRH_NEGATIVE = 8'h81;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BBU_OP_SET,
    BBU_OP_TEST,
    BBU_OP_CLEAR,
    BBU_OP_NONE
  } bbu_op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bbu_flags_t;

  typedef struct packed {
    logic        valid;
    logic        write_back;
    logic [15:0] result;
    logic        n;
    logic        z;
  } bbu_logic_res_t;

  typedef struct packed {
    logic        is_branch;
    logic        taken;
    logic [15:0] target;
  } bbu_branch_res_t;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] pc;
    bbu_flags_t  flags;
    logic [15:0] result;
    logic        done;
    logic        taken;
    logic        illegal;
    logic [31:0] prdata;
    logic        pslverr;
  } bbu_state_t;

endpackage

// *** bbu_logic_unit.sv ***
// bit set / bit test / bit clear datapath, word and byte forms
`timescale 1ns/100ps
module bbu_logic_unit (
  input  wire logic [15:0]         instr,
  input  wire logic [15:0]         src,
  input  wire logic [15:0]         dst,
  output bbu_pkg::bbu_logic_res_t  res
);

  logic [2:0]       opc;
  logic             is_byte;
  logic [15:0]      raw;
  bbu_pkg::bbu_op_t op;

  assign opc     = instr[bbu_pkg::INSTR_OPC_HI:bbu_pkg::INSTR_OPC_LO];
  assign is_byte = instr[bbu_pkg::INSTR_BYTE_BIT];

  always_comb begin
    case (opc)
      bbu_pkg::OPC_SET:   op = bbu_pkg::BBU_OP_SET;
      bbu_pkg::OPC_TEST:  op = bbu_pkg::BBU_OP_TEST;
      bbu_pkg::OPC_CLEAR: op = bbu_pkg::BBU_OP_CLEAR;
      default:            op = bbu_pkg::BBU_OP_NONE;
    endcase
  end

  always_comb begin
    case (op)
      bbu_pkg::BBU_OP_SET:   raw = dst | src;
      bbu_pkg::BBU_OP_TEST:  raw = dst & src;
      bbu_pkg::BBU_OP_CLEAR: raw = dst & ~src;
      default:               raw = dst;
    endcase
  end

  always_comb begin
    res.valid      = (op != bbu_pkg::BBU_OP_NONE);
    res.write_back = (op == bbu_pkg::BBU_OP_SET) ||
                     (op == bbu_pkg::BBU_OP_CLEAR);
    if (is_byte) begin
      // byte form: only the low byte moves, high byte kept
      res.result = {dst[15:8], raw[7:0]};
      res.n      = raw[7];
      res.z      = (raw[7:0] == 8'h00);
    end else begin
      res.result = raw;
      res.n      = raw[15];
      res.z      = (raw == bbu_pkg::RST_WORD);
    end
  end

endmodule

// *** bbu_branch_unit.sv ***
// branch decode, condition test and target arithmetic
`timescale 1ns/100ps
module bbu_branch_unit (
  input  wire logic [15:0]          instr,
  input  wire bbu_pkg::bbu_flags_t  flags,
  input  wire logic [15:0]          pc,
  output bbu_pkg::bbu_branch_res_t  res
);

  logic [15:0] offs_bytes;

  // word count, bit 7 is the sign, doubled to bytes
  assign offs_bytes = {{7{instr[7]}}, instr[7:0], 1'b0};

  always_comb begin
    res.is_branch = 1'b1;
    res.taken     = 1'b0;
    // pc already points past the branch word
    res.target    = pc + offs_bytes;
    case (instr[15:8])
      bbu_pkg::BRH_ALWAYS:   res.taken = 1'b1;
      bbu_pkg::BRH_ZERO:     res.taken = flags.z;
      bbu_pkg::BRH_NONZERO:  res.taken = !flags.z;
      bbu_pkg::BRH_NEGATIVE: res.taken = flags.n;
      default:               res.is_branch = 1'b0;
    endcase
  end

endmodule

// *** test_bbu_top.sv ***
// self-checking bench for the bit-op and branch unit over apb
`timescale 1ns/100ps
module test_bbu_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          bad_count;
  int          n_checks;
  string       nq[$];
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic        rq[$];

  bbu_top u_bbu_top (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master: one idle cycle after each transfer
  // ----------------------------------------------------------------
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      bad_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hFFFF_FFFF, logic er = 1'b0);
    nq.push_back(nm);
    eq.push_back(e & m);
    mq.push_back(m);
    rq.push_back(er);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // monitor: pops the oldest note on every completed read
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (eq.size() == 0) begin
        bad_count++;
        $display("CHECK FAILED stray read expected none seen %h", prdata);
      end else begin
        chk(nq[0], eq[0], prdata & mq[0]);
        chk({nq[0], " err"}, {31'h0, rq[0]}, {31'h0, pslverr});
        void'(nq.pop_front());
        void'(eq.pop_front());
        void'(mq.pop_front());
        void'(rq.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] s, d, r, nd, pc, ins, ep;
    logic [7:0]  off, hb;
    logic [3:0]  fl, ef;
    logic [31:0] rm;
    logic        n, z, tk;
    logic [7:0]  hbs[4];
    hbs = '{bbu_pkg::BRH_ALWAYS, bbu_pkg::BRH_NONZERO,
            bbu_pkg::BRH_ZERO, bbu_pkg::BRH_NEGATIVE};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(35));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then an unmapped place
    for (int a = 4; a < 32; a += 4)
      rd("reset value", 8'(a), 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    $display("test reset done");
    // logical ops, word and byte, with forced all-ones src and forced zero dst cases
    for (int k = 0; k < 4; k++)
      for (int op = 3; op < 6; op++)
        for (int b = 0; b < 2; b++) begin
          s = 16'($urandom);
          d = 16'($urandom);
          fl = 4'($urandom);
          if (k == 0) s = 16'hFFFF;
          if (k == 1) d = 16'h0000;
          ins = {1'(b), 3'(op), 12'($urandom)};
          r = (op == 5) ? (s | d) : (op == 3) ? (s & d) : (d & ~s);
          n = b ? r[7] : r[15];
          z = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
          nd = (op == 3) ? d : b ? {d[15:8], r[7:0]} : r;
          rm = b ? 32'h0000_00FF : 32'hFFFF_FFFF;
          ef = {n, z, 1'b0, fl[0]};
          wr(bbu_pkg::OFF_INSTR, {16'h0, ins});
          wr(bbu_pkg::OFF_SRC, {16'h0, s});
          wr(bbu_pkg::OFF_DST, {16'h0, d});
          wr(bbu_pkg::OFF_FLAGS, {28'h0, fl});
          wr(bbu_pkg::OFF_CTRL, 32'h0000_0001);
          rd("result", bbu_pkg::OFF_RESULT, {16'h0, r}, rm);
          rd("dst", bbu_pkg::OFF_DST, {16'h0, nd});
          rd("src", bbu_pkg::OFF_SRC, {16'h0, s});
          rd("flags", bbu_pkg::OFF_FLAGS, {28'h0, ef});
          rd("status", bbu_pkg::OFF_STATUS, 32'h0000_0001);
        end
    $display("test logical done");
    // branches: every code, extreme offsets, both flag states
    for (int h = 0; h < 4; h++)
      for (int k = 0; k < 6; k++) begin
        hb = hbs[h];
        off = (k < 2) ? 8'h80 : (k < 4) ? 8'h7F : 8'($urandom);
        fl = 4'($urandom);
        fl[3] = k[0];
        fl[2] = k[0];
        pc = 16'($urandom) & 16'hFFFE;
        tk = (h == 0) | ((h == 1) & ~fl[2]) | ((h == 2) & fl[2])
             | ((h == 3) & fl[3]);
        ep = tk ? pc + {{7{off[7]}}, off, 1'b0} : pc;
        wr(bbu_pkg::OFF_INSTR, {16'h0, hb, off});
        wr(bbu_pkg::OFF_PC, {16'h0, pc});
        wr(bbu_pkg::OFF_FLAGS, {28'h0, fl});
        wr(bbu_pkg::OFF_CTRL, 32'h0000_0001);
        rd("pc", bbu_pkg::OFF_PC, {16'h0, ep});
        rd("pc", bbu_pkg::OFF_PC, {16'h0, ep});
        rd("flags", bbu_pkg::OFF_FLAGS, {28'h0, fl});
        rd("status", bbu_pkg::OFF_STATUS, {30'h0, tk, 1'b1});
      end
    $display("test branch done");
    // unknown opcode leaves pc and flags alone, then done is cleared
    wr(bbu_pkg::OFF_INSTR, 32'h0000_0000);
    wr(bbu_pkg::OFF_CTRL, 32'h0000_0001);
    rd("illegal", bbu_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
    // last branch of the loop was taken, so the pc holds its target
    rd("pc kept", bbu_pkg::OFF_PC, {16'h0, ep});
    rd("flags kept", bbu_pkg::OFF_FLAGS, {28'h0, fl});
    wr(bbu_pkg::OFF_STATUS, 32'h0000_0001);
    rd("done clear", bbu_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_0001);
    $display("test illegal done");
    repeat (2) @(posedge pclk);
    if (eq.size() != 0) begin
      bad_count++;
      $display("CHECK FAILED pending reads expected 0 seen %0d", eq.size());
    end
    results();
  end
endmodule
